// *** logic/hbi_pkg.sv ***
package hbi_pkg;
    // ------------------------------------------------------------
    // Bus and register layout
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    typedef logic [ADDR_W-1:0] hbi_addr_t;
    localparam hbi_addr_t ADDR_CSEL_RXA = 4'h0;
    localparam hbi_addr_t ADDR_CSEL_TXA = 4'h1;
    localparam hbi_addr_t ADDR_CSEL_RXB = 4'h2;
    localparam hbi_addr_t ADDR_CSEL_TXB = 4'h3;
    localparam hbi_addr_t ADDR_AUX_CHG = 4'h4;
    localparam hbi_addr_t ADDR_MASK_STAT = 4'h5;
    localparam hbi_addr_t ADDR_CT_UPPER = 4'h6;
    localparam hbi_addr_t ADDR_CT_LOWER = 4'h7;
    localparam hbi_addr_t ADDR_CT_START = 4'h8;
    localparam hbi_addr_t ADDR_CT_STOP = 4'h9;
    localparam hbi_addr_t ADDR_VECTOR = 4'hc;
    localparam hbi_addr_t ADDR_OUT_CFG = 4'hd;
    localparam logic [DATA_W-1:0] VECTOR_RST = 8'h00;
    localparam logic [DATA_W-1:0] REG_RST = 8'h00;
    // Auxiliary control fields
    localparam int AUX_CHG_EN_LSB = 0;
    localparam int AUX_CT_EXT = 4;
    // Interrupt status bit positions
    localparam int EV_TX_A = 0;
    localparam int EV_RX_A = 1;
    localparam int EV_BRK_A = 2;
    localparam int EV_CT = 3;
    localparam int EV_TX_B = 4;
    localparam int EV_RX_B = 5;
    localparam int EV_BRK_B = 6;
    localparam int EV_IN_CHG = 7;
    localparam int NUM_EVENTS = 8;
    localparam int NUM_LINES = 5;
    localparam int NUM_INPUTS = 4;
    // ------------------------------------------------------------
    // Baud rate generator
    // ------------------------------------------------------------
    localparam int NUM_RATES = 18;
    localparam int DIV_W = 13;
    localparam int STD_REF_HZ = 3686400;
    localparam int OVERSAMPLE = 16;
    localparam int BAUD_SCALE = 10;
    localparam int BAUD_X10 [NUM_RATES] = '{500, 750, 1100, 1345, 1500, 2000, 3000, 6000, 10500,
        12000, 18000, 20000, 24000, 48000, 72000, 96000, 192000, 384000};
    localparam int SAMPLE_RATE_IDX = 12;
    localparam int FASTEST_RATE_IDX = 17;
    function automatic int div_of(int b10);
        return (STD_REF_HZ * BAUD_SCALE + (OVERSAMPLE / 2) * b10) / (OVERSAMPLE * b10);
    endfunction
    // ------------------------------------------------------------
    // Clock selectors and counter
    // ------------------------------------------------------------
    localparam int NUM_SEL = 4;
    localparam int SEL_W = 5;
    typedef logic [SEL_W-1:0] hbi_sel_t;
    localparam hbi_sel_t SEL_CT = 5'h12;
    localparam hbi_sel_t SEL_EXT = 5'h13;
    localparam hbi_sel_t SEL_RST = 5'h00;
    localparam int CT_W = 16;
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_ACK = 3'b010,
        BUS_REL = 3'b100
    } hbi_bus_t;
endpackage

// *** logic/hbi_baud_if.sv ***
`timescale 1ns/1ps
interface hbi_baud_if;
    logic [hbi_pkg::NUM_RATES-1:0] rate_tick;
    logic [hbi_pkg::CT_W-1:0] ct_preset;
    logic ct_start;
    logic ct_ext_sel;
    logic ct_ext_tick;
    logic ct_tick;
    logic ct_zero;
    logic ct_square;
    modport brg (output rate_tick);
    modport ct (input ct_preset, ct_start, ct_ext_sel, ct_ext_tick, output ct_tick, ct_zero, ct_square);
    modport top (input rate_tick, ct_tick, ct_zero, ct_square, output ct_preset, ct_start, ct_ext_sel,
        ct_ext_tick);
endinterface

// *** logic/hbi_brg.sv ***
`timescale 1ns/1ps
module hbi_brg (
    input wire logic ref_clk,
    input wire logic rst_b,
    hbi_baud_if.brg b
);
    import hbi_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    genvar i;
    for (i = 0; i < NUM_RATES; i++) begin : g_rate
        localparam logic [DIV_W-1:0] LAST = DIV_W'(div_of(BAUD_X10[i]) - 1);
        logic [DIV_W-1:0] cnt_q;
        logic tick_q;
        // One 16X pulse every divisor cycles of the reference
        always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
                cnt_q <= '0;
                tick_q <= 1'b0;
            end else if (cnt_q == '0) begin
                cnt_q <= LAST;
                tick_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q - 1'b1;
                tick_q <= 1'b0;
            end
        end
        assign b.rate_tick[i] = tick_q;
    end

    sequence fast_gap;
        !b.rate_tick[FASTEST_RATE_IDX] [*5] ##1 b.rate_tick[FASTEST_RATE_IDX];
    endsequence
    a_fast_rate_period: assert property (b.rate_tick[FASTEST_RATE_IDX] |=> fast_gap)
        else $error("fastest rate tick period wrong");
    a_slow_rate_gap: assert property (b.rate_tick[0] |=> !b.rate_tick[0] [*8])
        else $error("slowest rate ticks too close");
endmodule

// *** logic/hbi_ctr.sv ***
`timescale 1ns/1ps
module hbi_ctr (
    input wire logic ref_clk,
    input wire logic rst_b,
    hbi_baud_if.ct c
);
    import hbi_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    logic [CT_W-1:0] cnt_q;
    logic run_q;
    logic zero_q;
    logic tick_q;
    logic square_q;
    logic step;

    // Counts the reference or the synchronised external clock
    assign step = run_q && (!c.ct_ext_sel || c.ct_ext_tick);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
            run_q <= 1'b0;
        end else if (c.ct_start) begin
            cnt_q <= c.ct_preset;
            run_q <= 1'b1;
        end else if (step) begin
            cnt_q <= (cnt_q == '0) ? c.ct_preset : cnt_q - 1'b1;
        end
    end

    // Square wave; each rising half gives one 16X pulse
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            zero_q <= 1'b0;
            tick_q <= 1'b0;
            square_q <= 1'b0;
        end else begin
            zero_q <= step && cnt_q == '0;
            tick_q <= step && cnt_q == '0 && !square_q;
            if (step && cnt_q == '0) begin
                square_q <= !square_q;
            end
        end
    end

    assign c.ct_zero = zero_q;
    assign c.ct_tick = tick_q;
    assign c.ct_square = square_q;

    a_ct_reload: assert property ((step && cnt_q == '0 && !c.ct_start) |=> cnt_q == $past(c.ct_preset))
        else $error("counter did not reload preset");
endmodule

// *** logic/hbi_top.sv ***
`timescale 1ns/1ps
module hbi_top (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic chip_select_n,
    input wire logic irq_ack_n,
    input wire logic read_write_n,
    input wire logic [hbi_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [hbi_pkg::DATA_W-1:0] data_in,
    output logic [hbi_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    output logic transfer_ack_n,
    output logic transfer_ack_oe,
    output logic irq_request_n,
    output logic irq_request_oe,
    input wire logic [5:0] chan_conditions,
    input wire logic [hbi_pkg::NUM_INPUTS-1:0] input_pins,
    input wire logic counter_ext_clock,
    input wire logic [1:0] receive_ext_clock,
    input wire logic [1:0] transmit_ext_clock,
    input wire logic [hbi_pkg::NUM_LINES-1:0] general_out,
    output logic [hbi_pkg::NUM_LINES-1:0] output_lines_3_to_7,
    output logic [hbi_pkg::NUM_LINES-1:0] output_lines_oe,
    output logic [hbi_pkg::NUM_SEL-1:0] clk16_tick,
    output logic ct_square
);
    import hbi_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int SYNC_W = 3 + ADDR_W + DATA_W + NUM_SEL + 1 + NUM_INPUTS;
    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;
    logic cs_s;
    logic iack_s;
    logic rw_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] din_s;
    logic [NUM_SEL-1:0] ext_s;
    logic counter_ext_clock_s;
    logic [NUM_INPUTS-1:0] ip_s;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= {input_pins, counter_ext_clock, transmit_ext_clock[1], receive_ext_clock[1],
                transmit_ext_clock[0], receive_ext_clock[0], data_in, reg_addr, read_write_n,
                irq_ack_n, chip_select_n};
            sync_q <= meta_q;
        end
    end
    assign {ip_s, counter_ext_clock_s, ext_s, din_s, addr_s, rw_s, iack_s, cs_s} = sync_q;

    // ------------------------------------------------------------
    // Bus acknowledge
    // ------------------------------------------------------------
    hbi_bus_t bus_q;
    logic irq_pend;
    logic sel_cyc;
    logic iack_cyc;
    logic wr_pulse;
    logic rd_pulse;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] data_out_q;
    logic [DATA_W-1:0] ivr_q;
    logic data_oe_q;
    logic ack_n_q;
    logic ack_oe_q;

    assign sel_cyc = bus_q == BUS_IDLE && !cs_s;
    assign iack_cyc = bus_q == BUS_IDLE && cs_s && !iack_s && irq_pend;
    assign wr_pulse = sel_cyc && !rw_s;
    assign rd_pulse = sel_cyc && rw_s;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_q <= BUS_IDLE;
        end else begin
            unique case (bus_q)
                BUS_IDLE: begin
                    if (sel_cyc || iack_cyc) begin
                        bus_q <= BUS_ACK;
                    end
                end
                BUS_ACK: begin
                    if (cs_s && iack_s) begin
                        bus_q <= BUS_REL;
                    end
                end
                BUS_REL: begin
                    bus_q <= BUS_IDLE;
                end
            endcase
        end
    end

    // Acknowledge is driven high for one cycle before release
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_n_q <= 1'b1;
            ack_oe_q <= 1'b0;
        end else begin
            ack_n_q <= !(sel_cyc || iack_cyc || (bus_q == BUS_ACK && !(cs_s && iack_s)));
            ack_oe_q <= sel_cyc || iack_cyc || bus_q == BUS_ACK;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            data_out_q <= '0;
            data_oe_q <= 1'b0;
        end else if (iack_cyc) begin
            data_out_q <= ivr_q;
            data_oe_q <= 1'b1;
        end else if (rd_pulse) begin
            data_out_q <= rd_data;
            data_oe_q <= 1'b1;
        end else if (bus_q == BUS_ACK && cs_s && iack_s) begin
            data_oe_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Host registers
    // ------------------------------------------------------------
    logic [DATA_W-1:0] imr_q;
    logic [DATA_W-1:0] acr_q;
    logic [DATA_W-1:0] opcr_q;
    logic [DATA_W-1:0] ctu_q;
    logic [DATA_W-1:0] ctl_q;
    hbi_sel_t csel_q [NUM_SEL];
    logic [NUM_EVENTS-1:0] status_q;
    logic [NUM_INPUTS-1:0] chg_q;
    logic [NUM_INPUTS-1:0] lvl_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            imr_q <= REG_RST;
            ivr_q <= VECTOR_RST;
            acr_q <= REG_RST;
            opcr_q <= REG_RST;
            ctu_q <= REG_RST;
            ctl_q <= REG_RST;
            for (int k = 0; k < NUM_SEL; k++) begin
                csel_q[k] <= SEL_RST;
            end
        end else if (wr_pulse) begin
            if (addr_s == ADDR_MASK_STAT) imr_q <= din_s;
            if (addr_s == ADDR_VECTOR) ivr_q <= din_s;
            if (addr_s == ADDR_AUX_CHG) acr_q <= din_s;
            if (addr_s == ADDR_OUT_CFG) opcr_q <= din_s;
            if (addr_s == ADDR_CT_UPPER) ctu_q <= din_s;
            if (addr_s == ADDR_CT_LOWER) ctl_q <= din_s;
            if (addr_s == ADDR_CSEL_RXA) csel_q[0] <= din_s[SEL_W-1:0];
            if (addr_s == ADDR_CSEL_TXA) csel_q[1] <= din_s[SEL_W-1:0];
            if (addr_s == ADDR_CSEL_RXB) csel_q[2] <= din_s[SEL_W-1:0];
            if (addr_s == ADDR_CSEL_TXB) csel_q[3] <= din_s[SEL_W-1:0];
        end
    end

    always_comb begin
        rd_data = '0;
        unique case (addr_s)
            ADDR_MASK_STAT: rd_data = status_q;
            ADDR_AUX_CHG: rd_data = {lvl_q, chg_q};
            ADDR_VECTOR: rd_data = ivr_q;
            ADDR_OUT_CFG: rd_data = opcr_q;
            ADDR_CT_UPPER: rd_data = ctu_q;
            ADDR_CT_LOWER: rd_data = ctl_q;
            default: rd_data = '0;
        endcase
    end

    // ------------------------------------------------------------
    // Generator, counter and selectors
    // ------------------------------------------------------------
    hbi_baud_if bif ();
    logic [NUM_SEL-1:0] ext_prev_q;
    logic counter_ext_clock_prev_q;
    logic [NUM_SEL-1:0] ext_rise;
    logic [NUM_SEL-1:0] clk16_q;
    logic ct_square_q;

    hbi_brg u_brg (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .b(bif.brg)
    );
    hbi_ctr u_ctr (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .c(bif.ct)
    );

    assign bif.ct_preset = {ctu_q, ctl_q};
    assign bif.ct_start = wr_pulse && addr_s == ADDR_CT_START;
    assign bif.ct_ext_sel = acr_q[AUX_CT_EXT];
    assign bif.ct_ext_tick = counter_ext_clock_s && !counter_ext_clock_prev_q;
    assign ext_rise = ext_s & ~ext_prev_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_prev_q <= '1;
            counter_ext_clock_prev_q <= 1'b1;
            ct_square_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_s;
            counter_ext_clock_prev_q <= counter_ext_clock_s;
            ct_square_q <= bif.ct_square;
        end
    end

    genvar g;
    for (g = 0; g < NUM_SEL; g++) begin : g_sel
        always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
                clk16_q[g] <= 1'b0;
            end else if (csel_q[g] < SEL_W'(NUM_RATES)) begin
                clk16_q[g] <= bif.rate_tick[csel_q[g]];
            end else if (csel_q[g] == SEL_CT) begin
                clk16_q[g] <= bif.ct_tick;
            end else if (csel_q[g] == SEL_EXT) begin
                clk16_q[g] <= ext_rise[g];
            end else begin
                clk16_q[g] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Input change detection
    // ------------------------------------------------------------
    logic [NUM_INPUTS-1:0] smp_q;
    logic [NUM_INPUTS-1:0] chg_set;
    logic chg_rd;

    // A change counts only after two samples agree at the new level
    assign chg_set = bif.rate_tick[SAMPLE_RATE_IDX] ? ((ip_s ~^ smp_q) & (ip_s ^ lvl_q)) : '0;
    assign chg_rd = rd_pulse && addr_s == ADDR_AUX_CHG;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            smp_q <= '1;
            lvl_q <= '1;
            chg_q <= '0;
        end else begin
            if (bif.rate_tick[SAMPLE_RATE_IDX]) begin
                smp_q <= ip_s;
                lvl_q <= lvl_q ^ chg_set;
            end
            chg_q <= (chg_q & ~{NUM_INPUTS{chg_rd}}) | chg_set;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, request and output lines
    // ------------------------------------------------------------
    logic ct_flag_q;
    logic ct_stop;
    logic [NUM_LINES-1:0] line_irq;
    logic [NUM_LINES-1:0] lines_q;
    logic [NUM_LINES-1:0] lines_oe_q;
    logic irq_n_q;
    logic irq_oe_q;

    assign ct_stop = wr_pulse && addr_s == ADDR_CT_STOP;
    assign irq_pend = |(status_q & imr_q);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ct_flag_q <= 1'b0;
        end else if (bif.ct_zero) begin
            ct_flag_q <= 1'b1;
        end else if (ct_stop) begin
            ct_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_q <= '0;
        end else begin
            status_q <= {|(chg_q & acr_q[AUX_CHG_EN_LSB +: NUM_INPUTS]), chan_conditions[5:3],
                ct_flag_q, chan_conditions[2:0]};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_n_q <= 1'b1;
            irq_oe_q <= 1'b0;
        end else begin
            irq_n_q <= !irq_pend;
            irq_oe_q <= irq_pend;
        end
    end

    assign line_irq = {status_q[EV_TX_B], status_q[EV_TX_A], status_q[EV_RX_B], status_q[EV_RX_A],
        status_q[EV_CT]};

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            lines_q <= '1;
            lines_oe_q <= '1;
        end else begin
            lines_q <= general_out & ~opcr_q[NUM_LINES-1:0];
            lines_oe_q <= ~opcr_q[NUM_LINES-1:0] | line_irq;
        end
    end

    assign data_out = data_out_q;
    assign data_oe = data_oe_q;
    assign transfer_ack_n = ack_n_q;
    assign transfer_ack_oe = ack_oe_q;
    assign irq_request_n = irq_n_q;
    assign irq_request_oe = irq_oe_q;
    assign output_lines_3_to_7 = lines_q;
    assign output_lines_oe = lines_oe_q;
    assign clk16_tick = clk16_q;
    assign ct_square = ct_square_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence ack_driven;
        !transfer_ack_n && transfer_ack_oe;
    endsequence
    a_ack_on_select: assert property (sel_cyc |=> ack_driven)
        else $error("no acknowledge after select");
    a_ack_holds_low: assert property ((bus_q == BUS_ACK && !cs_s) |=> ack_driven)
        else $error("acknowledge dropped while selected");
    a_vector_on_iack: assert property (iack_cyc |=> ack_driven and (data_oe && data_out == $past(ivr_q)))
        else $error("vector not returned on interrupt acknowledge");
    a_status_read_back: assert property (rd_pulse && addr_s == ADDR_MASK_STAT |=> data_out == $past(status_q))
        else $error("status read wrong");
    a_irq_on_enabled: assert property (irq_pend |=> !irq_request_n && irq_request_oe)
        else $error("request not asserted");
    a_irq_masked_off: assert property (!(|(status_q & imr_q)) |=> irq_request_n && !irq_request_oe)
        else $error("masked event raised request");
    a_ct_set_wins: assert property (bif.ct_zero |=> ##1 status_q[EV_CT])
        else $error("counter event lost");
    a_ct_stop_clears: assert property ((ct_stop && !bif.ct_zero) |=> !ct_flag_q ##1 !status_q[EV_CT])
        else $error("stop did not clear counter event");
    a_line_open_drain: assert property (opcr_q[0] |=> !output_lines_3_to_7[0]
        && output_lines_oe[0] == $past(line_irq[0]))
        else $error("interrupt line not open drain");
    a_sel_external: assert property ((csel_q[0] == SEL_EXT && ext_rise[0]) |=> clk16_tick[0])
        else $error("external clock not selected");
endmodule

// *** bench/hbi_host_model.sv ***
`timescale 1ns/1ps
module hbi_host_model
    import hbi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic transfer_ack_n,
    input wire logic transfer_ack_oe,
    output logic chip_select_n,
    output logic irq_ack_n,
    output logic read_write_n,
    output logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] data_in
);
    initial begin
        chip_select_n = 1'b1;
        irq_ack_n = 1'b1;
        read_write_n = 1'b1;
        reg_addr = '0;
        data_in = '0;
    end
    // Request held until acknowledged or for 8 cycles; released data and address lines show the inverse
    task automatic cycle(input logic ia, input logic rd, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q, output logic ok);
        ok = 1'b0;
        q = '0;
        @(posedge ref_clk);
        #1;
        read_write_n = rd;
        reg_addr = a;
        data_in = d;
        irq_ack_n = ~ia;
        chip_select_n = ia;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(posedge ref_clk);
            if (transfer_ack_n === 1'b0 && transfer_ack_oe === 1'b1) begin
                ok = 1'b1;
                q = data_out;
            end
        end
        #1;
        chip_select_n = 1'b1;
        irq_ack_n = 1'b1;
        data_in = ~d;
        reg_addr = ~a;
        for (int i = 0; i < 8 && transfer_ack_oe !== 1'b0; i++) @(posedge ref_clk);
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
endmodule

// *** bench/host_bus_interrupt_and_baud_clock_tb.sv ***
`timescale 1ns/1ps
module host_bus_interrupt_and_baud_clock_tb;
    import hbi_pkg::*;
    logic ref_clk, rst_b, chip_select_n, irq_ack_n, read_write_n, data_oe, transfer_ack_n, transfer_ack_oe;
    logic irq_request_n, irq_request_oe, ct_square, ok, xclk;
    localparam int XH = 10;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] data_in, data_out, q, v, m;
    logic [5:0] chan_conditions;
    logic [NUM_INPUTS-1:0] pins;
    logic [NUM_LINES-1:0] general_out, output_lines_3_to_7, output_lines_oe;
    logic [NUM_SEL-1:0] clk16_tick;
    logic [31:0] seed = 32'hb18e;
    int errors = 0;
    int checks_done = 0;
    int n;
    hbi_top u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .chip_select_n(chip_select_n), .irq_ack_n(irq_ack_n),
        .read_write_n(read_write_n), .reg_addr(reg_addr), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .transfer_ack_n(transfer_ack_n), .transfer_ack_oe(transfer_ack_oe),
        .irq_request_n(irq_request_n), .irq_request_oe(irq_request_oe), .chan_conditions(chan_conditions),
        .input_pins(pins), .counter_ext_clock(xclk), .receive_ext_clock({2{xclk}}), .transmit_ext_clock({2{xclk}}),
        .general_out(general_out), .output_lines_3_to_7(output_lines_3_to_7),
        .output_lines_oe(output_lines_oe), .clk16_tick(clk16_tick), .ct_square(ct_square));
    hbi_host_model u_host (.ref_clk(ref_clk), .data_out(data_out), .transfer_ack_n(transfer_ack_n),
        .transfer_ack_oe(transfer_ack_oe), .chip_select_n(chip_select_n), .irq_ack_n(irq_ack_n),
        .read_write_n(read_write_n), .reg_addr(reg_addr), .data_in(data_in));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // External timing input shared by counter and selectors
    initial begin
        xclk = 1'b0;
        forever begin
            repeat (XH) @(posedge ref_clk);
            #1 xclk = ~xclk;
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] stat_of(input logic [5:0] c);
        return {1'b0, c[5:3], 1'b0, c[2:0]};
    endfunction
    function automatic int per_of(input int b);
        return (4608000 + b) / (2 * b);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        u_host.cycle(1'b0, 1'b0, a, d, q, ok);
        chk(ok, 1'b1);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        u_host.cycle(1'b0, 1'b1, a, seed[7:0], q, ok);
        chk(ok, 1'b1);
    endtask
    task automatic tick_gap(input int i, output int g);
        g = 0;
        for (int w = 0; w < 20000 && clk16_tick[i] !== 1'b1; w++) @(posedge ref_clk) #1;
        @(posedge ref_clk) #1;
        g = 1;
        while (clk16_tick[i] !== 1'b1 && g < 20000) begin
            @(posedge ref_clk) #1;
            g++;
        end
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge ref_clk);
        errors++;
        report_and_stop;
    end
    initial begin
        rst_b = 1'b0;
        chan_conditions = '0;
        general_out = '0;
        pins = '1;
        repeat (6) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        chk({transfer_ack_n, transfer_ack_oe, irq_request_n, irq_request_oe, data_oe}, 5'h14);
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            v = seed[7:0];
            wr(ADDR_VECTOR, v);
            rd(ADDR_VECTOR);
            chk(q, v);
        end
        rd(4'hf);
        chk(q, 8'h00);
        $display("bus test done");
        for (int k = 0; k < 10; k++) begin
            seed = xs(seed);
            chan_conditions = (k < 3) ? 6'h3f : seed[5:0];
            m = (k == 1) ? 8'hff : (k == 2) ? 8'h00 : seed[15:8];
            wr(ADDR_MASK_STAT, m);
            rd(ADDR_MASK_STAT);
            chk(q, stat_of(chan_conditions));
            n = |(stat_of(chan_conditions) & m);
            chk({irq_request_n, irq_request_oe}, {~n[0], n[0]});
            u_host.cycle(1'b1, 1'b1, 4'h0, 8'h00, q, ok);
            chk({ok, ok ? q : 8'h00}, {n[0], n[0] ? v : 8'h00});
        end
        $display("interrupt test done");
        chan_conditions = '0;
        wr(ADDR_CT_UPPER, 8'h01);
        wr(ADDR_CT_LOWER, 8'h00);
        wr(ADDR_MASK_STAT, 8'h08);
        wr(ADDR_CT_START, 8'h00);
        repeat (600) @(posedge ref_clk);
        rd(ADDR_MASK_STAT);
        chk({q[EV_CT], irq_request_n}, 2'b10);
        wr(ADDR_CT_STOP, 8'h00);
        chk(irq_request_n, 1'b1);
        $display("counter test done");
        for (int i = 0; i < NUM_SEL; i++) begin
            wr(hbi_addr_t'(i), 8'(FASTEST_RATE_IDX - i));
            tick_gap(i, n);
            chk(16'(n), 16'(per_of(BAUD_X10[FASTEST_RATE_IDX - i])));
        end
        seed = xs(seed);
        n = seed % NUM_RATES;
        wr(ADDR_CSEL_RXA, 8'(n));
        tick_gap(0, n);
        chk(16'(n), 16'(per_of(BAUD_X10[seed % NUM_RATES])));
        $display("baud test done");
        pins = 4'he;
        wr(ADDR_AUX_CHG, 8'h1f);
        wr(ADDR_MASK_STAT, 8'h80);
        wr(ADDR_CT_UPPER, 8'h00);
        wr(ADDR_CT_LOWER, 8'h02);
        wr(ADDR_CT_START, 8'h00);
        wr(ADDR_CSEL_RXA, 8'(SEL_EXT));
        wr(ADDR_CSEL_TXA, 8'(SEL_CT));
        tick_gap(0, n);
        chk(16'(n), 16'(2 * XH));
        tick_gap(1, n);
        chk(16'(n), 16'(2 * (2 + 1) * 2 * XH));
        chk({clk16_tick[1], ct_square}, 2'b11);
        rd(ADDR_MASK_STAT);
        chk({q[EV_IN_CHG], irq_request_n}, 2'b10);
        rd(ADDR_AUX_CHG);
        chk(q, 8'he1);
        rd(ADDR_MASK_STAT);
        chk({q[EV_IN_CHG], irq_request_n}, 2'b01);
        $display("input change and external clock test done");
        general_out = seed[12:8];
        chan_conditions = 6'h02;
        wr(ADDR_OUT_CFG, 8'h02);
        repeat (4) @(posedge ref_clk);
        chk({output_lines_oe[1:0], output_lines_3_to_7[1:0]}, {2'b11, 1'b0, general_out[0]});
        chan_conditions = 6'h00;
        repeat (4) @(posedge ref_clk);
        chk(output_lines_oe[1], 1'b0);
        $display("output line test done");
        report_and_stop;
    end
endmodule
